// File: lane_range_pkg.sv
// Constants shared by the lane and range frame packer
package lane_range_pkg;
    localparam int FIELD_BITS = 16;
    localparam int WIDE_BITS = 32;
    localparam int RAW_BITS = 32;
    localparam int RAW_WIDE_BITS = 34;
    localparam int FRAC_BITS = 2;
    localparam logic signed [35:0] ROUND_HALF = 36'sh2;
    localparam logic [15:0] NEG_FULL = 16'h8000;
    localparam logic [15:0] POS_FULL = 16'h7FFF;
    localparam int NUM_LINES = 8;
    localparam int NUM_LANE_WORDS = 24;
    localparam int NUM_LEVER_WORDS = 9;
    localparam int NUM_TARGETS = 4;
    localparam int NUM_RANGE = 8;
    localparam int NUM_FRAMES = 17;
    localparam logic [4:0] LAST_LANE_IDX = 5'h05;
    localparam logic [4:0] LAST_LEVER_IDX = 5'h08;
    localparam logic [4:0] FIRST_RANGE_IDX = 5'h09;
    localparam logic [4:0] FRAME_END = 5'h11;
    localparam logic [10:0] ID_CURV_LO = 11'h7AA;
    localparam logic [10:0] ID_LEVER_A = 11'h5A0;
    localparam logic [10:0] ID_RANGE_BASE = 11'h7B0;
    localparam logic [10:0] ID_TARGET_STEP = 11'h010;
    localparam logic [3:0] FRAME_DLC = 4'h8;
    localparam int TTC_BITS = 40;
    localparam logic [39:0] TTC_SCALE = 40'h64;
    localparam logic [5:0] DIV_STEPS = 6'h28;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DIVIDE = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_SEND = 4'b1000
    } pack_state_type;
endpackage

// File: ttc_divider.sv
// Serial restoring divider for the time-to-collision fields
`timescale 1ns/100ps
`default_nettype none
module ttc_divider (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [lane_range_pkg::TTC_BITS-1:0] dividend_i,
    input wire logic [15:0] divisor_i,
    output logic done_o,
    output logic [lane_range_pkg::TTC_BITS-1:0] quotient_o
);
    import lane_range_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [16:0] rem;
        logic [TTC_BITS-1:0] quo;
    } div_state_type;

    div_state_type s_reg;
    div_state_type s_next;
    logic [16:0] shifted;

    ////////////////////////////////////////////////////////////////////
    // A zero divisor yields all ones, which the caller saturates
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        shifted = {s_reg.rem[15:0], s_reg.quo[TTC_BITS-1]};
        if (start_i) begin
            s_next.busy = 1'b1;
            s_next.cnt = DIV_STEPS;
            s_next.rem = 17'h00000;
            s_next.quo = dividend_i;
        end else if (s_reg.busy) begin
            s_next.quo = {s_reg.quo[TTC_BITS-2:0], 1'b0};
            s_next.rem = shifted;
            if (shifted >= {1'b0, divisor_i}) begin
                s_next.rem = shifted - {1'b0, divisor_i};
                s_next.quo[0] = 1'b1;
            end
            s_next.cnt = s_reg.cnt - 6'h01;
            if (s_reg.cnt == 6'h01) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done_o = s_reg.done;
    assign quotient_o = s_reg.quo;
endmodule
`default_nettype wire

// File: lane_range_can_frame_packer.sv
// Packs lane and range measurements into eight-byte CAN data frames
`timescale 1ns/100ps
`default_nettype none
module lane_range_can_frame_packer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic lane_valid_i,
    input wire logic [7:0][lane_range_pkg::RAW_BITS-1:0] curv_i,
    input wire logic [7:0][lane_range_pkg::RAW_BITS-1:0] pointb_dist_i,
    input wire logic [7:0][lane_range_pkg::RAW_BITS-1:0] pointc_dist_i,
    input wire logic [8:0][lane_range_pkg::RAW_BITS-1:0] lever_i,
    input wire logic [3:0][lane_range_pkg::RAW_WIDE_BITS-1:0]
        longitudinal_distance_i,
    input wire logic [3:0][lane_range_pkg::RAW_BITS-1:0]
        longitudinal_speed_i,
    input wire logic [3:0][lane_range_pkg::RAW_WIDE_BITS-1:0]
        sideways_distance_i,
    input wire logic [3:0][lane_range_pkg::RAW_BITS-1:0] sideways_speed_i,
    input wire logic frame_ready_i,
    output logic frame_valid_o,
    output logic [10:0] frame_id_o,
    output logic [3:0] frame_dlc_o,
    output logic [63:0] frame_data_o,
    output logic busy_o
);
    import lane_range_pkg::*;

    typedef struct packed {
        pack_state_type st;
        logic busy;
        logic [4:0] idx;
        logic div_start;
        logic [NUM_LANE_WORDS-1:0][15:0] lane;
        logic [NUM_LEVER_WORDS-1:0][15:0] lever;
        logic [NUM_RANGE-1:0][31:0] rdist;
        logic [NUM_RANGE-1:0][15:0] rspd;
        logic [NUM_RANGE-1:0][15:0] ttc;
        logic valid;
        logic [10:0] id;
        logic [63:0] data;
        logic [3:0] dlc;
    } pack_type;

    pack_type s_reg;
    pack_type s_next;
    logic div_done;
    logic [TTC_BITS-1:0] quotient;
    logic [TTC_BITS-1:0] dividend;
    logic [15:0] divisor;

    ////////////////////////////////////////////////////////////////////
    // Round half up, then clamp to a 16- or 32-bit signed field
    function automatic logic [31:0] round_sat(
        input logic signed [35:0] x,
        input logic wide
    );
        logic signed [35:0] r;
        logic signed [35:0] hi;
        logic signed [35:0] lo;
        r = (x + ROUND_HALF) >>> FRAC_BITS;
        hi = wide ? 36'sh07FFFFFFF : 36'sh000007FFF;
        lo = wide ? -36'sh080000000 : -36'sh000008000;
        if (r > hi) begin
            round_sat = wide ? 32'h7FFFFFFF : {16'h0000, POS_FULL};
        end else if (r < lo) begin
            round_sat = wide ? 32'h80000000 : {16'h0000, NEG_FULL};
        end else begin
            round_sat = wide ? r[31:0] : {16'h0000, r[15:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Time to collision in 0.01 s is 100 * range / -speed
    logic r_neg;
    logic v_neg;
    logic [31:0] r_mag;
    logic [15:0] t_mag;

    always_comb begin
        r_neg = s_reg.rdist[s_reg.idx[2:0]][31];
        v_neg = s_reg.rspd[s_reg.idx[2:0]][15];
        r_mag = r_neg ? 32'(-s_reg.rdist[s_reg.idx[2:0]])
                      : s_reg.rdist[s_reg.idx[2:0]];
        divisor = v_neg ? 16'(-s_reg.rspd[s_reg.idx[2:0]])
                        : s_reg.rspd[s_reg.idx[2:0]];
        dividend = 40'(r_mag) * TTC_SCALE;
        t_mag = (quotient > 40'(POS_FULL)) ? POS_FULL : quotient[15:0];
    end

    ttc_divider u_div (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(s_reg.div_start),
        .dividend_i(dividend),
        .divisor_i(divisor),
        .done_o(div_done),
        .quotient_o(quotient)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer: snapshot, eight divisions, then seventeen frames
    logic [4:0] base;
    logic [4:0] ridx;
    logic [2:0] tgt;

    always_comb begin
        s_next = s_reg;
        s_next.div_start = 1'b0;
        base = 5'h00;
        ridx = 5'h00;
        tgt = 3'h0;
        unique case (s_reg.st)
            ST_IDLE: begin
                // Inputs are captured once so every frame of a round agrees
                if (start_i) begin
                    for (int i = 0; i < NUM_LINES; i++) begin
                        s_next.lane[i] = lane_valid_i
                            ? 16'(round_sat(36'(signed'(curv_i[i])), 1'b0))
                            : NEG_FULL;
                        s_next.lane[i+8] = lane_valid_i
                            ? 16'(round_sat(36'(signed'(pointb_dist_i[i])),
                              1'b0)) : NEG_FULL;
                        s_next.lane[i+16] = lane_valid_i
                            ? 16'(round_sat(36'(signed'(pointc_dist_i[i])),
                              1'b0)) : NEG_FULL;
                    end
                    for (int i = 0; i < NUM_LEVER_WORDS; i++) begin
                        s_next.lever[i] =
                            16'(round_sat(36'(signed'(lever_i[i])), 1'b0));
                    end
                    for (int t = 0; t < NUM_TARGETS; t++) begin
                        s_next.rdist[t] = round_sat(36'(signed'(
                            longitudinal_distance_i[t])), 1'b1);
                        s_next.rspd[t] = 16'(round_sat(36'(signed'(
                            longitudinal_speed_i[t])), 1'b0));
                        s_next.rdist[t+4] = round_sat(36'(signed'(
                            sideways_distance_i[t])), 1'b1);
                        s_next.rspd[t+4] = 16'(round_sat(36'(signed'(
                            sideways_speed_i[t])), 1'b0));
                    end
                    s_next.idx = 5'h00;
                    s_next.busy = 1'b1;
                    s_next.st = ST_DIVIDE;
                end
            end
            ST_DIVIDE: begin
                s_next.div_start = 1'b1;
                s_next.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (div_done) begin
                    // Standing still never closes: report the positive limit
                    if (divisor == 16'h0000) begin
                        s_next.ttc[s_reg.idx[2:0]] = POS_FULL;
                    end else if (r_neg == v_neg) begin
                        s_next.ttc[s_reg.idx[2:0]] = 16'(-t_mag);
                    end else begin
                        s_next.ttc[s_reg.idx[2:0]] = t_mag;
                    end
                    if (s_reg.idx == 5'h07) begin
                        s_next.idx = 5'h00;
                        s_next.st = ST_SEND;
                    end else begin
                        s_next.idx = s_reg.idx + 5'h01;
                        s_next.st = ST_DIVIDE;
                    end
                end
            end
            ST_SEND: begin
                if (!s_reg.valid || frame_ready_i) begin
                    if (s_reg.idx == FRAME_END) begin
                        s_next.valid = 1'b0;
                        s_next.busy = 1'b0;
                        s_next.st = ST_IDLE;
                    end else begin
                        s_next.valid = 1'b1;
                        s_next.data = 64'h0000000000000000;
                        s_next.idx = s_reg.idx + 5'h01;
                        if (s_reg.idx <= LAST_LANE_IDX) begin
                            base = 5'(s_reg.idx * 5'h04);
                            s_next.id = ID_CURV_LO
                                + 11'(s_reg.idx);
                            for (int j = 0; j < 4; j++) begin
                                s_next.data[j*16 +: 16] =
                                    s_reg.lane[base + 5'(j)];
                            end
                        end else if (s_reg.idx <= LAST_LEVER_IDX) begin
                            base = 5'((s_reg.idx - 5'h06) * 5'h03);
                            s_next.id = ID_LEVER_A
                                + 11'(s_reg.idx - 5'h06);
                            for (int j = 0; j < 3; j++) begin
                                s_next.data[j*16 +: 16] =
                                    s_reg.lever[base + 5'(j)];
                            end
                        end else begin
                            ridx = s_reg.idx - FIRST_RANGE_IDX;
                            tgt = {1'b0, ridx[2:1]};
                            // Even slots longitudinal, odd slots sideways
                            s_next.id = ID_RANGE_BASE
                                + 11'(tgt) * ID_TARGET_STEP
                                + 11'(ridx[0]);
                            s_next.data[31:0] =
                                s_reg.rdist[{ridx[0], tgt[1:0]}];
                            s_next.data[47:32] =
                                s_reg.rspd[{ridx[0], tgt[1:0]}];
                            s_next.data[63:48] =
                                s_reg.ttc[{ridx[0], tgt[1:0]}];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.dlc <= FRAME_DLC;
        end else begin
            s_reg <= s_next;
        end
    end

    assign frame_valid_o = s_reg.valid;
    assign frame_id_o = s_reg.id;
    assign frame_dlc_o = s_reg.dlc;
    assign frame_data_o = s_reg.data;
    assign busy_o = s_reg.busy;
endmodule
`default_nettype wire

// File: lane_range_can_frame_packer_assertions.sv
// Port checks for the lane and range frame packer
`timescale 1ns/100ps
`default_nettype none
module lane_range_checker
    import lane_range_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic lane_valid_i,
    input wire logic frame_ready_i,
    input wire logic frame_valid_o,
    input wire logic [10:0] frame_id_o,
    input wire logic [3:0] frame_dlc_o,
    input wire logic [63:0] frame_data_o,
    input wire logic busy_o
);
    logic lane_off_reg;
    // Starts during a round are ignored, so only latch when idle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lane_off_reg <= 1'b0;
        end else if (start_i && !busy_o) begin
            lane_off_reg <= !lane_valid_i;
        end
    end
    default clocking chk_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence take_s;
        frame_valid_o && frame_ready_i;
    endsequence
    sequence took_s(logic [10:0] id);
        take_s ##0 frame_id_o == id;
    endsequence
    ////////////////////////////////////////////////////////////////////
    frame_hold_a: assert property (frame_valid_o && !frame_ready_i |=>
        frame_valid_o && $stable(frame_id_o) && $stable(frame_data_o))
        else $error("frame changed before acceptance");
    dlc_eight_a: assert property (frame_valid_o |->
        frame_dlc_o == FRAME_DLC) else $error("payload length not eight");
    lane_order_a: assert property (
        take_s ##0 (frame_id_o >= 11'h7AA && frame_id_o <= 11'h7AE)
        |=> frame_valid_o && frame_id_o == $past(frame_id_o) + 11'h001)
        else $error("lane frame order broken");
    lever_entry_a: assert property (took_s(11'h7AF) |=>
        frame_valid_o && frame_id_o == 11'h5A0)
        else $error("lever frames not after lane frames");
    lever_order_a: assert property (
        take_s ##0 (frame_id_o == 11'h5A0 || frame_id_o == 11'h5A1)
        |=> frame_valid_o && frame_id_o == $past(frame_id_o) + 11'h001)
        else $error("lever frame order broken");
    range_entry_a: assert property (took_s(11'h5A2) |=>
        frame_valid_o && frame_id_o == 11'h7B0)
        else $error("first range frame wrong");
    target_step_a: assert property (
        take_s ##0 (frame_id_o[3:0] == 4'h1 &&
        frame_id_o[10:4] inside {7'h7B, 7'h7C, 7'h7D})
        |=> frame_id_o == $past(frame_id_o) + 11'h00F)
        else $error("target step not 10h");
    side_follow_a: assert property (
        take_s ##0 (frame_id_o[3:0] == 4'h0 && frame_id_o >= 11'h7B0)
        |=> frame_id_o == $past(frame_id_o) + 11'h001)
        else $error("sideways frame does not follow");
    round_end_a: assert property (took_s(11'h7E1) |=>
        !frame_valid_o && !busy_o) else $error("round did not end");
    lever_pad_a: assert property (
        frame_valid_o && frame_id_o[10:8] == 3'h5
        |-> frame_data_o[63:48] == 16'h0000)
        else $error("lever pad not zero");
    lane_blank_a: assert property (frame_valid_o && lane_off_reg &&
        frame_id_o >= 11'h7AA && frame_id_o <= 11'h7AF |->
        frame_data_o == {4{NEG_FULL}}) else $error("lane field not blanked");
endmodule
bind lane_range_can_frame_packer lane_range_checker lane_range_checker_inst (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(start_i),
    .lane_valid_i(lane_valid_i),
    .frame_ready_i(frame_ready_i),
    .frame_valid_o(frame_valid_o),
    .frame_id_o(frame_id_o),
    .frame_dlc_o(frame_dlc_o),
    .frame_data_o(frame_data_o),
    .busy_o(busy_o)
);
`default_nettype wire

// File: can_frame_receiver.sv
// Receiver model that accepts frames with a set stall after each
`timescale 1ns/100ps
`default_nettype none
module can_frame_receiver (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic frame_valid_i,
    input wire logic [10:0] frame_id_i,
    input wire logic [3:0] frame_dlc_i,
    input wire logic [63:0] frame_data_i,
    input wire logic [3:0] stall_i,
    output logic frame_ready_o
);
    logic [10:0] id_q [$];
    logic [63:0] data_q [$];
    logic [3:0] dlc_q [$];
    logic [3:0] wait_cnt;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_ready_o <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (frame_valid_i && frame_ready_o) begin
            id_q.push_back(frame_id_i);
            data_q.push_back(frame_data_i);
            dlc_q.push_back(frame_dlc_i);
            frame_ready_o <= (stall_i == 4'h0);
            wait_cnt <= stall_i;
        end else if (wait_cnt > 4'h1) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else begin
            wait_cnt <= 4'h0;
            frame_ready_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: lane_range_can_frame_packer_bench.sv
// Self-checking bench for the lane and range frame packer
`timescale 1ns/100ps
`default_nettype none
module lane_range_can_frame_packer_bench;
    import lane_range_pkg::*;
    logic core_clk_i, rst_i, start_i, lane_valid_i, frame_ready_i;
    logic frame_valid_o, busy_o;
    logic [7:0][31:0] curv_i, pointb_dist_i, pointc_dist_i;
    logic [8:0][31:0] lever_i;
    logic [3:0][33:0] longitudinal_distance_i, sideways_distance_i;
    logic [3:0][31:0] longitudinal_speed_i, sideways_speed_i;
    logic [10:0] frame_id_o;
    logic [3:0] frame_dlc_o, stall_cfg;
    logic [63:0] frame_data_o;
    logic [15:0] lane_f [24];
    logic [15:0] lev_f [9];
    int num_errors, samples_checked;
    lane_range_can_frame_packer lane_range_can_frame_packer_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i),
        .lane_valid_i(lane_valid_i), .curv_i(curv_i),
        .pointb_dist_i(pointb_dist_i), .pointc_dist_i(pointc_dist_i),
        .lever_i(lever_i), .longitudinal_distance_i(longitudinal_distance_i),
        .longitudinal_speed_i(longitudinal_speed_i),
        .sideways_distance_i(sideways_distance_i),
        .sideways_speed_i(sideways_speed_i), .frame_ready_i(frame_ready_i),
        .frame_valid_o(frame_valid_o), .frame_id_o(frame_id_o),
        .frame_dlc_o(frame_dlc_o), .frame_data_o(frame_data_o),
        .busy_o(busy_o));
    can_frame_receiver can_frame_receiver_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .frame_valid_i(frame_valid_o), .frame_id_i(frame_id_o),
        .frame_dlc_i(frame_dlc_o), .frame_data_i(frame_data_o),
        .stall_i(stall_cfg), .frame_ready_o(frame_ready_i));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] raw16(input logic [15:0] f);
        return {{14{f[15]}}, f, 2'b00};
    endfunction
    // Target 2 is far enough out to clip its forward time to collision
    function automatic int dist_of(input int n);
        if (n == 13) return 40000;
        return ((n - 9) % 2) ? 500 : 1000 * ((n - 9) / 2 + 1);
    endfunction
    // Target 3 stands still longitudinally; target 2 opens sideways, giving a negative value
    function automatic int spd_of(input int n);
        return ((n - 9) % 2) ? ((n == 14) ? 50 : -50)
            : ((n == 15) ? 0 : -100);
    endfunction
    function automatic logic [10:0] exp_id(input int n);
        if (n < 6) return 11'h7AA + 11'(n);
        if (n < 9) return 11'h5A0 + 11'(n - 6);
        return 11'h7B0 + 11'(((n - 9) / 2) * 16 + (n - 9) % 2);
    endfunction
    function automatic logic [63:0] exp_data(input int n, input logic on);
        int d, s, v;
        if (n < 6) return on ? {lane_f[4*n+3], lane_f[4*n+2],
            lane_f[4*n+1], lane_f[4*n]} : {4{NEG_FULL}};
        if (n < 9) return {16'h0000, lev_f[3*n-16], lev_f[3*n-17],
            lev_f[3*n-18]};
        d = dist_of(n);
        s = spd_of(n);
        v = (s == 0) ? 32767 : 100 * d / (-s);
        return {(v > 32767) ? 16'h7FFF : v[15:0], s[15:0], d[31:0]};
    endfunction
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run_round(input logic on, input logic [3:0] stall,
        input logic extra);
        int i;
        can_frame_receiver_inst.id_q.delete();
        can_frame_receiver_inst.data_q.delete();
        can_frame_receiver_inst.dlc_q.delete();
        @(posedge core_clk_i);
        lane_valid_i <= on;
        stall_cfg <= stall;
        start_i <= 1'b1;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        if (extra) begin
            repeat (5) @(posedge core_clk_i);
            start_i <= 1'b1;
            @(posedge core_clk_i);
            start_i <= 1'b0;
        end
        i = 0;
        @(negedge core_clk_i);
        while (busy_o !== 1'b0 && i < 3000) begin
            @(negedge core_clk_i);
            i++;
        end
        if (i >= 3000) begin
            num_errors++;
            report_and_stop();
        end
        repeat (8) @(negedge core_clk_i);
        check(64'(can_frame_receiver_inst.id_q.size()), 64'd17);
        for (i = 0; i < can_frame_receiver_inst.id_q.size(); i++) begin
            check(64'(can_frame_receiver_inst.id_q[i]),
                64'(exp_id(i)));
            check(can_frame_receiver_inst.data_q[i],
                exp_data(i, on));
            check(64'(can_frame_receiver_inst.dlc_q[i]), 64'h8);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic valid_stream_test();
        run_round(1'b1, 4'h0, 1'b0);
    endtask
    task automatic mid_reset_test();
        @(posedge core_clk_i);
        start_i <= 1'b1;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        repeat (50) @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(64'({busy_o, frame_valid_o, frame_dlc_o}), 64'h8);
        @(posedge core_clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic lane_off_test();
        run_round(1'b0, 4'h3, 1'b1);
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        rst_i = 1'b1;
        start_i = 1'b0;
        lane_valid_i = 1'b0;
        stall_cfg = 4'h0;
        num_errors = 0;
        samples_checked = 0;
        for (int k = 0; k < 24; k++) lane_f[k] = 16'h0100 + 16'(k);
        lane_f[1] = 16'hFFFB;
        for (int k = 0; k < 8; k++) begin
            curv_i[k] = raw16(lane_f[k]);
            pointb_dist_i[k] = raw16(lane_f[8+k]);
            pointc_dist_i[k] = raw16(lane_f[16+k]);
        end
        pointc_dist_i[7] = 32'h7FFF0000;
        lane_f[23] = 16'h7FFF;
        for (int k = 0; k < 9; k++) begin
            lev_f[k] = 16'h0200 + 16'(k);
            lever_i[k] = raw16(lev_f[k]);
        end
        lever_i[0] = 32'h00000016;
        lev_f[0] = 16'h0006;
        lever_i[8] = 32'h80000000;
        lev_f[8] = 16'h8000;
        for (int t = 0; t < 4; t++) begin
            longitudinal_distance_i[t] = 34'(dist_of(9 + 2 * t) * 4);
            longitudinal_speed_i[t] = 32'(spd_of(9 + 2 * t) * 4);
            sideways_distance_i[t] = 34'(dist_of(10 + 2 * t) * 4);
            sideways_speed_i[t] = 32'(spd_of(10 + 2 * t) * 4);
        end
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        valid_stream_test();
        mid_reset_test();
        lane_off_test();
        report_and_stop();
    end
endmodule
`default_nettype wire
